// >>> rtl/loop_dac_consts.svh
// Shared constants of the loop converter serial command port
`ifndef LOOP_DAC_CONSTS_SVH
`define LOOP_DAC_CONSTS_SVH

// Frame lengths in bits
`define FRAME_BITS       6'd24
`define FRAME_CRC_BITS   6'd32
`define FRAME_OVER_BITS  6'd33

// Field positions inside a 24-bit frame
`define CMD_MSB          23
`define CMD_LSB          16
`define DATA_MSB         15
`define DATA_LSB         0

// Command bytes
`define CMD_WR_DAC       8'h01
`define CMD_WR_CTRL      8'h02
`define CMD_WR_OFFSET    8'h03
`define CMD_WR_GAIN      8'h04
`define CMD_LOAD_DAC     8'h05
`define CMD_ALARM        8'h06
`define CMD_RESET        8'h07
`define CMD_MEASURE      8'h08
`define CMD_NOP          8'h09
`define CMD_RD_DAC       8'h81
`define CMD_RD_CTRL      8'h82
`define CMD_RD_OFFSET    8'h83
`define CMD_RD_GAIN      8'h84
`define CMD_RD_FAULT     8'h85

// Control bit that turns off automatic fault readback
`define CTRL_NO_AUTO_BIT 11

// Reset values
`define DAC_RESET        16'h0000
`define CTRL_RESET       16'h0000
`define OFFSET_RESET     16'h8000
`define GAIN_RESET       16'hFFFF

// Checksum polynomial, x^8 + x^2 + x + 1
`define CRC_POLY         8'h07

// Timing
`define CLK_PERIOD_NS    50
`define RESET_WAIT_NS    50000
`define SCLK_HALF_CYC    4

`endif

// >>> rtl/loop_dac_pkg.sv
// Types and the checksum function of the loop converter serial port
`include "loop_dac_consts.svh"

package loop_dac_pkg;

    typedef logic [15:0] word_type;

    // Register selected for serial readback
    typedef enum logic [2:0] {SEL_FAULT, SEL_DAC, SEL_CTRL, SEL_OFFSET, SEL_GAIN} read_sel_type;

    // Host sequencer states
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_SHIFT, H_TAIL, H_GAP} host_state_type;

    // Checksum over command and data, MSB first, zero seed
    function automatic logic [7:0] crc8_calc(input logic [23:0] bits);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--) begin
            c = (c[7] ^ bits[i]) ? ({c[6:0], 1'b0} ^ `CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : crc8_calc

endpackage : loop_dac_pkg

// >>> rtl/loop_dac_link_if.sv
// Four-wire serial link between host and converter port
`timescale 1ns/1ps

interface loop_dac_link_if;
    logic sync_b;
    logic sclk;
    logic serial_data_in;
    logic serial_data_out;

    modport device (
        input  sync_b,
        input  sclk,
        input  serial_data_in,
        output serial_data_out
    );

    modport host (
        output sync_b,
        output sclk,
        output serial_data_in,
        input  serial_data_out
    );
endinterface : loop_dac_link_if

// >>> rtl/loop_dac_serial_command_port.sv
// Device end: serial command port of the loop converter
// How it works
// - Host opens each frame by lowering sync_b
// - Input bits sampled on shift clock falling edge
// - Rising sync_b latches frame and executes it
// - 32-bit frame with checksum byte accepted
// - Bits arrive and assemble MSB first
// - Command byte on top, data word below
// - Codes 02-04 write control, offset, gain
// - 05 loads output, 06 forces alarm
// - 07 resets; host waits 50 us after
// - 08 measures, 09 idles, data ignored
// - Codes 81-85 select readback registers
// - Host sets control D11 before reads
// - Selected register shifts out next frame
// - Data word of reads is ignored
// - Host shift clock at most 30 MHz
// - Free-running or burst shift clock both work
// - Host steps codes to limit slew rate
// - Measure powers converter, result in fault
// - Valid write or no-op restarts watchdog
`timescale 1ns/1ps
`include "loop_dac_consts.svh"

module loop_dac_serial_command_port #(
    parameter logic [15:0] DAC_INIT    = `DAC_RESET,
    parameter logic [15:0] CTRL_INIT   = `CTRL_RESET,
    parameter logic [15:0] OFFSET_INIT = `OFFSET_RESET,
    parameter logic [15:0] GAIN_INIT   = `GAIN_RESET
) (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    // Serial link
    loop_dac_link_if.device            link,
    // Configuration and status from the converter core
    input  wire logic                  crc_enable,
    input  wire loop_dac_pkg::word_type fault_word,
    // Register contents toward the converter core
    output logic [15:0]                dac_code,
    output logic [15:0]                dac_output,
    output logic [15:0]                ctrl_word,
    output logic [15:0]                offset_word,
    output logic [15:0]                gain_word,
    output logic                       alarm_active,
    // One-cycle event strobes
    output logic                       meas_start,
    output logic                       wd_restart,
    output logic                       soft_reset,
    output logic                       crc_error
);
    import loop_dac_pkg::*;

    // Pin synchronisers
    logic sclk_s1, sclk_s2, sclk_s3;
    logic sync_s1, sync_s2, sync_s3;
    logic din_s1,  din_s2;

    // Frame and register state
    logic [31:0]  rx_reg,     rx_next;
    logic [5:0]   cnt_reg,    cnt_next;
    logic [23:0]  tx_reg,     tx_next;
    logic         sdo_reg,    sdo_next;
    read_sel_type sel_reg,    sel_next;
    logic [15:0]  dac_reg,    dac_next;
    logic [15:0]  out_reg,    out_next;
    logic [15:0]  ctrl_reg,   ctrl_next;
    logic [15:0]  offset_reg, offset_next;
    logic [15:0]  gain_reg,   gain_next;
    logic         alarm_reg,  alarm_next;
    logic         meas_reg,   meas_next;
    logic         wd_reg,     wd_next;
    logic         rst_reg,    rst_next;
    logic         crcerr_reg, crcerr_next;

    // Decoded edges and frame view
    logic         sclk_fall;
    logic         frame_start;
    logic         frame_end;
    logic [23:0]  frame;
    logic [7:0]   cmd;
    logic [15:0]  data;
    logic         len_ok;
    logic         crc_ok;
    logic [15:0]  rd_word;

    // Two flops on every pin before any logic looks at it
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_s3 <= 1'b1;
            sync_s1 <= 1'b1;
            sync_s2 <= 1'b1;
            sync_s3 <= 1'b1;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
        end else if (ce) begin
            sclk_s1 <= link.sclk;
            sclk_s2 <= sclk_s1;
            sclk_s3 <= sclk_s2;
            sync_s1 <= link.sync_b;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
            din_s1  <= link.serial_data_in;
            din_s2  <= din_s1;
        end
    end

    // Edges seen one cycle after the second flop
    assign sclk_fall   = sclk_s3 & ~sclk_s2;
    assign frame_start = sync_s3 & ~sync_s2;
    assign frame_end   = ~sync_s3 & sync_s2;

    // A 32-bit frame carries its checksum in the low byte
    assign frame  = (cnt_reg == `FRAME_CRC_BITS) ? rx_reg[31:8] : rx_reg[23:0];
    assign cmd    = frame[`CMD_MSB:`CMD_LSB];
    assign data   = frame[`DATA_MSB:`DATA_LSB];
    assign crc_ok = (crc8_calc(rx_reg[31:8]) == rx_reg[7:0]);
    assign len_ok = crc_enable ? (cnt_reg == `FRAME_CRC_BITS && crc_ok)
                               : (cnt_reg == `FRAME_BITS || cnt_reg == `FRAME_CRC_BITS);

    // Word for the next frame; without D11 set the fault word always returns
    always_comb begin
        rd_word = fault_word;
        if (!ctrl_reg[`CTRL_NO_AUTO_BIT]) begin
            rd_word = fault_word;
        end else begin
            unique case (sel_reg)
                SEL_DAC:    rd_word = dac_reg;
                SEL_CTRL:   rd_word = ctrl_reg;
                SEL_OFFSET: rd_word = offset_reg;
                SEL_GAIN:   rd_word = gain_reg;
                SEL_FAULT:  rd_word = fault_word;
            endcase
        end
    end

    // Shifting, decode and register updates
    always_comb begin
        rx_next     = rx_reg;
        cnt_next    = cnt_reg;
        tx_next     = tx_reg;
        sdo_next    = sdo_reg;
        sel_next    = sel_reg;
        dac_next    = dac_reg;
        out_next    = out_reg;
        ctrl_next   = ctrl_reg;
        offset_next = offset_reg;
        gain_next   = gain_reg;
        alarm_next  = alarm_reg;
        meas_next   = 1'b0;
        wd_next     = 1'b0;
        rst_next    = 1'b0;
        crcerr_next = 1'b0;
        if (frame_start) begin
            // Readback word is frozen here so a late register write cannot tear it
            cnt_next = 6'd0;
            tx_next  = {8'h00, rd_word};
            sdo_next = 1'b0;
        end else if (!sync_s2 && sclk_fall) begin
            // Gated bursts and free clocks look alike: only falls inside a frame count
            rx_next  = {rx_reg[30:0], din_s2};
            cnt_next = (cnt_reg == `FRAME_OVER_BITS) ? cnt_reg : cnt_reg + 6'd1;
            tx_next  = {tx_reg[22:0], 1'b0};
            sdo_next = tx_reg[22];
        end
        if (frame_end) begin
            crcerr_next = crc_enable && !len_ok && cnt_reg == `FRAME_CRC_BITS;
            if (len_ok) begin
                unique case (cmd)
                    `CMD_WR_DAC: begin
                        dac_next = data;
                        wd_next  = 1'b1;
                    end
                    `CMD_WR_CTRL: begin
                        ctrl_next = data;
                        wd_next   = 1'b1;
                    end
                    `CMD_WR_OFFSET: begin
                        offset_next = data;
                        wd_next     = 1'b1;
                    end
                    `CMD_WR_GAIN: begin
                        gain_next = data;
                        wd_next   = 1'b1;
                    end
                    `CMD_LOAD_DAC: begin
                        out_next   = dac_reg;
                        alarm_next = 1'b0;
                    end
                    `CMD_ALARM:    alarm_next = 1'b1;
                    `CMD_RESET: begin
                        // Data word is ignored by every non-write command
                        dac_next    = DAC_INIT;
                        out_next    = DAC_INIT;
                        ctrl_next   = CTRL_INIT;
                        offset_next = OFFSET_INIT;
                        gain_next   = GAIN_INIT;
                        alarm_next  = 1'b1;
                        sel_next    = SEL_FAULT;
                        rst_next    = 1'b1;
                    end
                    `CMD_MEASURE:   meas_next = 1'b1;
                    `CMD_NOP:       wd_next   = 1'b1;
                    `CMD_RD_DAC:    sel_next  = SEL_DAC;
                    `CMD_RD_CTRL:   sel_next  = SEL_CTRL;
                    `CMD_RD_OFFSET: sel_next  = SEL_OFFSET;
                    `CMD_RD_GAIN:   sel_next  = SEL_GAIN;
                    `CMD_RD_FAULT:  sel_next  = SEL_FAULT;
                    default:        sel_next  = sel_reg;
                endcase
            end
        end
    end

    // Register the port state; power-up leaves the loop in alarm
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rx_reg     <= 32'h0000_0000;
            cnt_reg    <= 6'd0;
            tx_reg     <= 24'h00_0000;
            sdo_reg    <= 1'b0;
            sel_reg    <= SEL_FAULT;
            dac_reg    <= DAC_INIT;
            out_reg    <= DAC_INIT;
            ctrl_reg   <= CTRL_INIT;
            offset_reg <= OFFSET_INIT;
            gain_reg   <= GAIN_INIT;
            alarm_reg  <= 1'b1;
            meas_reg   <= 1'b0;
            wd_reg     <= 1'b0;
            rst_reg    <= 1'b0;
            crcerr_reg <= 1'b0;
        end else if (ce) begin
            rx_reg     <= rx_next;
            cnt_reg    <= cnt_next;
            tx_reg     <= tx_next;
            sdo_reg    <= sdo_next;
            sel_reg    <= sel_next;
            dac_reg    <= dac_next;
            out_reg    <= out_next;
            ctrl_reg   <= ctrl_next;
            offset_reg <= offset_next;
            gain_reg   <= gain_next;
            alarm_reg  <= alarm_next;
            meas_reg   <= meas_next;
            wd_reg     <= wd_next;
            rst_reg    <= rst_next;
            crcerr_reg <= crcerr_next;
        end
    end

    // Outputs straight from flops
    assign link.serial_data_out = sdo_reg;
    assign dac_code     = dac_reg;
    assign dac_output   = out_reg;
    assign ctrl_word    = ctrl_reg;
    assign offset_word  = offset_reg;
    assign gain_word    = gain_reg;
    assign alarm_active = alarm_reg;
    assign meas_start   = meas_reg;
    assign wd_restart   = wd_reg;
    assign soft_reset   = rst_reg;
    assign crc_error    = crcerr_reg;

endmodule : loop_dac_serial_command_port

// >>> rtl/loop_dac_serial_host.sv
// Host end: serial master that sends one command frame per request
`timescale 1ns/1ps
`include "loop_dac_consts.svh"

module loop_dac_serial_host #(
    parameter int HALF_CYC = `SCLK_HALF_CYC
) (
    // Clock, reset, enable
    input  wire logic                  clk,
    input  wire logic                  rst_b,
    input  wire logic                  ce,
    // Serial link
    loop_dac_link_if.host              link,
    // Request
    input  wire logic                  req_valid,
    input  wire logic [7:0]            req_cmd,
    input  wire loop_dac_pkg::word_type req_data,
    input  wire logic                  req_use_crc,
    output logic                       req_ready,
    // Answer: word shifted back during the frame
    output logic                       resp_valid,
    output logic [15:0]                resp_word
);
    import loop_dac_pkg::*;

    // Least wait after a reset command, rounded up to whole cycles
    localparam int RESET_WAIT_CYC = (`RESET_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;

    logic           sdo_s1, sdo_s2;
    host_state_type st_reg,   st_next;
    logic [9:0]     tmr_reg,  tmr_next;
    logic [5:0]     bits_reg, bits_next;
    logic [31:0]    tx_reg,   tx_next;
    logic [31:0]    rx_reg,   rx_next;
    logic           crc_reg,  crc_next;
    logic           long_reg, long_next;
    logic           sync_reg, sync_next;
    logic           sclk_reg, sclk_next;
    logic           din_reg,  din_next;
    logic           rdy_reg,  rdy_next;
    logic           rv_reg,   rv_next;
    logic [15:0]    rw_reg,   rw_next;

    // Data returned by the device crosses two flops first
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            sdo_s1 <= 1'b0;
            sdo_s2 <= 1'b0;
        end else if (ce) begin
            sdo_s1 <= link.serial_data_out;
            sdo_s2 <= sdo_s1;
        end
    end

    // Frame sequencer; clock is gated, so it only toggles inside a frame
    always_comb begin
        st_next   = st_reg;
        tmr_next  = (tmr_reg == 10'd0) ? tmr_reg : tmr_reg - 10'd1;
        bits_next = bits_reg;
        tx_next   = tx_reg;
        rx_next   = rx_reg;
        crc_next  = crc_reg;
        long_next = long_reg;
        sync_next = sync_reg;
        sclk_next = sclk_reg;
        din_next  = din_reg;
        rdy_next  = rdy_reg;
        rv_next   = 1'b0;
        rw_next   = rw_reg;
        unique case (st_reg)
            H_IDLE: begin
                if (req_valid) begin
                    tx_next   = {req_cmd, req_data, req_use_crc ? crc8_calc({req_cmd, req_data}) : 8'h00};
                    bits_next = req_use_crc ? `FRAME_CRC_BITS : `FRAME_BITS;
                    crc_next  = req_use_crc;
                    long_next = (req_cmd == `CMD_RESET);
                    sync_next = 1'b0;
                    sclk_next = 1'b1;
                    din_next  = req_cmd[7];
                    // Long lead lets the device load its readback word first
                    tmr_next  = 10'(2 * HALF_CYC - 1);
                    rdy_next  = 1'b0;
                    st_next   = H_LEAD;
                end
            end
            H_LEAD, H_SHIFT: begin
                if (tmr_reg == 10'd0) begin
                    tmr_next = 10'(HALF_CYC - 1);
                    st_next  = H_SHIFT;
                    if (sclk_reg) begin
                        // Device samples this fall; read its bit at the same moment
                        sclk_next = 1'b0;
                        rx_next   = {rx_reg[30:0], sdo_s2};
                        bits_next = bits_reg - 6'd1;
                    end else begin
                        sclk_next = 1'b1;
                        tx_next   = {tx_reg[30:0], 1'b0};
                        din_next  = tx_reg[30];
                        if (bits_reg == 6'd0) begin
                            st_next = H_TAIL;
                        end
                    end
                end
            end
            H_TAIL: begin
                if (tmr_reg == 10'd0) begin
                    sync_next = 1'b1;
                    rv_next   = 1'b1;
                    rw_next   = crc_reg ? rx_reg[23:8] : rx_reg[15:0];
                    tmr_next  = long_reg ? 10'(RESET_WAIT_CYC - 1) : 10'(2 * HALF_CYC - 1);
                    st_next   = H_GAP;
                end
            end
            H_GAP: begin
                if (tmr_reg == 10'd0) begin
                    rdy_next = 1'b1;
                    st_next  = H_IDLE;
                end
            end
        endcase
    end

    // Register the sequencer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            st_reg   <= H_IDLE;
            tmr_reg  <= 10'd0;
            bits_reg <= 6'd0;
            tx_reg   <= 32'h0000_0000;
            rx_reg   <= 32'h0000_0000;
            crc_reg  <= 1'b0;
            long_reg <= 1'b0;
            sync_reg <= 1'b1;
            sclk_reg <= 1'b1;
            din_reg  <= 1'b0;
            rdy_reg  <= 1'b1;
            rv_reg   <= 1'b0;
            rw_reg   <= 16'h0000;
        end else if (ce) begin
            st_reg   <= st_next;
            tmr_reg  <= tmr_next;
            bits_reg <= bits_next;
            tx_reg   <= tx_next;
            rx_reg   <= rx_next;
            crc_reg  <= crc_next;
            long_reg <= long_next;
            sync_reg <= sync_next;
            sclk_reg <= sclk_next;
            din_reg  <= din_next;
            rdy_reg  <= rdy_next;
            rv_reg   <= rv_next;
            rw_reg   <= rw_next;
        end
    end

    // Outputs straight from flops
    assign link.sync_b         = sync_reg;
    assign link.sclk           = sclk_reg;
    assign link.serial_data_in = din_reg;
    assign req_ready           = rdy_reg;
    assign resp_valid          = rv_reg;
    assign resp_word           = rw_reg;

endmodule : loop_dac_serial_host

// >>> verif/loop_dac_link_chk.sv
// Wire-level checks on the host-device serial link
`timescale 1ns/1ps

module loop_dac_link_chk (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Link wires
    input wire logic sync_b,
    input wire logic sclk,
    input wire logic serial_data_in,
    input wire logic serial_data_out
);
    logic [5:0] falls_reg;
    logic [5:0] falls_next;
    logic       sclk_reg;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);

    // Count shift clock falls inside a frame; cleared while deselected
    always_comb begin
        falls_next = falls_reg;
        if (sync_b) begin
            falls_next = 6'h00;
        end else if (sclk_reg && !sclk) begin
            falls_next = falls_reg + 6'h01;
        end
    end

    // Previous shift clock level lets the count see edges without a second clock
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            falls_reg <= 6'h00;
            sclk_reg  <= 1'b1;
        end else begin
            falls_reg <= falls_next;
            sclk_reg  <= sclk;
        end
    end

    property p_idle_high;
        sync_b |-> sclk;
    endproperty
    a_idle_high: assert property (p_idle_high) else $error("shift clock low outside a frame");
    property p_open;
        $fell(sync_b) |-> sclk && $past(sclk);
    endproperty
    a_open: assert property (p_open) else $error("frame opened with shift clock low");
    property p_din_stable;
        $fell(sclk) |-> $stable(serial_data_in);
    endproperty
    a_din_stable: assert property (p_din_stable) else $error("data moved at the sampling edge");
    property p_low_time;
        $fell(sclk) |=> !sclk[*3];
    endproperty
    a_low_time: assert property (p_low_time) else $error("shift clock low phase too short");
    property p_high_time;
        $rose(sclk) |=> sclk[*3];
    endproperty
    a_high_time: assert property (p_high_time) else $error("shift clock high phase too short");
    property p_gap;
        $rose(sync_b) |=> sync_b[*3];
    endproperty
    a_gap: assert property (p_gap) else $error("frame gap too short");
    property p_length;
        $rose(sync_b) |-> (falls_reg == 6'd24) || (falls_reg == 6'd32);
    endproperty
    a_length: assert property (p_length) else $error("frame length not 24 or 32");
    property p_lead_zero;
        !sync_b && falls_reg >= 6'd2 && falls_reg <= 6'd7 |-> !serial_data_out;
    endproperty
    a_lead_zero: assert property (p_lead_zero) else $error("readback lead bits not zero");
endmodule : loop_dac_link_chk

// >>> verif/test_loop_dac_serial_command_port.sv
// Bench joining host and device ends over the serial link
`timescale 1ns/1ps

module test_loop_dac_serial_command_port;
    import loop_dac_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       crc_en = 1'b0;
    logic       req_valid = 1'b0;
    logic [7:0] req_cmd = 8'h00;
    word_type   req_data = 16'h0000;
    logic       req_crc = 1'b0;
    word_type   fault = 16'hA5C3;
    logic       req_ready, resp_valid, alarm, meas, wd, srst, crc_err;
    word_type   resp_word, dac_code, dac_out, ctrl, offs, gain, got;
    int         fails = 0;
    int         checks = 0;
    int         meas_n = 0;
    int         wd_n = 0;
    int         srst_n = 0;
    int         crc_n = 0;
    logic [7:0] wr_cmd [4] = '{8'h01, 8'h02, 8'h03, 8'h04};
    word_type   wr_val [4] = '{16'h1234, 16'h0800, 16'h5A5A, 16'hC3C3};
    logic [7:0] rd_cmd [6] = '{8'h81, 8'h82, 8'h83, 8'h84, 8'h85, 8'h09};
    word_type   rd_exp [6];

    loop_dac_link_if loop_dac_link_if_inst ();
    loop_dac_serial_host loop_dac_serial_host_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .link(loop_dac_link_if_inst), .req_valid(req_valid), .req_cmd(req_cmd), .req_data(req_data),
        .req_use_crc(req_crc), .req_ready(req_ready), .resp_valid(resp_valid), .resp_word(resp_word));
    loop_dac_serial_command_port loop_dac_serial_command_port_inst (.clk(clk), .rst_b(rst_b), .ce(1'b1),
        .link(loop_dac_link_if_inst), .crc_enable(crc_en), .fault_word(fault), .dac_code(dac_code),
        .dac_output(dac_out), .ctrl_word(ctrl), .offset_word(offs), .gain_word(gain), .alarm_active(alarm),
        .meas_start(meas), .wd_restart(wd), .soft_reset(srst), .crc_error(crc_err));
    loop_dac_link_chk loop_dac_link_chk_inst (.clk(clk), .rst_b(rst_b), .sync_b(loop_dac_link_if_inst.sync_b),
        .sclk(loop_dac_link_if_inst.sclk), .serial_data_in(loop_dac_link_if_inst.serial_data_in),
        .serial_data_out(loop_dac_link_if_inst.serial_data_out));

    always #25 clk = ~clk;

    // Strobes stand one cycle, so they are tallied rather than polled
    always @(negedge clk) begin
        if (meas === 1'b1) meas_n++;
        if (wd === 1'b1) wd_n++;
        if (srst === 1'b1) srst_n++;
        if (crc_err === 1'b1) crc_n++;
    end

    task automatic stop_test();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test

    task automatic check(input word_type g, input word_type e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : check

    task automatic regs(input word_type d, input word_type c, input word_type o, input word_type g, input logic a);
        check(dac_code, d);
        check(ctrl, c);
        check(offs, o);
        check(gain, g);
        check({15'h0000, alarm}, {15'h0000, a});
    endtask : regs

    // One frame; returns the word shifted back and waits until the host is idle again
    task automatic send(input logic [7:0] cmd, input word_type data, input logic uc, input logic en,
                        output word_type w);
        int n;
        n = 0;
        @(posedge clk);
        req_valid <= 1'b1;
        req_cmd   <= cmd;
        req_data  <= data;
        req_crc   <= uc;
        crc_en    <= en;
        @(posedge clk);
        req_valid <= 1'b0;
        while (resp_valid !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        check({15'h0000, resp_valid}, 16'h0001);
        w = resp_word;
        while (req_ready !== 1'b1 && n < 1600) begin
            @(negedge clk);
            n++;
        end
        check({15'h0000, req_ready}, 16'h0001);
    endtask : send

    // Hang guard, a few times the expected run length
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        rd_exp = '{fault, 16'h1234, 16'h0800, 16'h5A5A, 16'hC3C3, fault};
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        @(negedge clk);
        regs(16'h0000, 16'h0000, 16'h8000, 16'hFFFF, 1'b1);
        $display("test reset_values done");
        send(8'h09, 16'hFFFF, 1'b0, 1'b0, got);
        check(got, fault);
        check(16'(wd_n), 16'h0001);
        $display("test auto_fault done");
        for (int i = 0; i < 4; i++) begin
            send(wr_cmd[i], wr_val[i], 1'b0, 1'b0, got);
        end
        regs(16'h1234, 16'h0800, 16'h5A5A, 16'hC3C3, 1'b1);
        check(16'(wd_n), 16'h0005);
        $display("test writes done");
        for (int i = 0; i < 6; i++) begin
            send(rd_cmd[i], 16'hFFFF, 1'b0, 1'b0, got);
            check(got, rd_exp[i]);
        end
        regs(16'h1234, 16'h0800, 16'h5A5A, 16'hC3C3, 1'b1);
        $display("test readback done");
        send(8'h05, 16'hDEAD, 1'b0, 1'b0, got);
        check(dac_out, 16'h1234);
        regs(16'h1234, 16'h0800, 16'h5A5A, 16'hC3C3, 1'b0);
        send(8'h08, 16'hBEEF, 1'b0, 1'b0, got);
        check(16'(meas_n), 16'h0001);
        send(8'h06, 16'h0000, 1'b0, 1'b0, got);
        regs(16'h1234, 16'h0800, 16'h5A5A, 16'hC3C3, 1'b1);
        $display("test functions done");
        for (int i = 1; i <= 3; i++) begin
            send(8'h01, 16'(i * 16'h4000), 1'b0, 1'b0, got);
            send(8'h05, 16'h0000, 1'b0, 1'b0, got);
            check(dac_out, 16'(i * 16'h4000));
        end
        $display("test slew_steps done");
        send(8'h04, 16'h1111, 1'b0, 1'b1, got);
        check(gain, 16'hC3C3);
        send(8'h04, 16'h2222, 1'b1, 1'b1, got);
        check(gain, 16'h2222);
        send(8'h04, 16'h3333, 1'b1, 1'b0, got);
        check(gain, 16'h3333);
        check(16'(crc_n), 16'h0000);
        $display("test checksum done");
        send(8'h07, 16'h1234, 1'b0, 1'b0, got);
        regs(16'h0000, 16'h0000, 16'h8000, 16'hFFFF, 1'b1);
        check(dac_out, 16'h0000);
        check(16'(srst_n), 16'h0001);
        send(8'h09, 16'h0000, 1'b0, 1'b0, got);
        check(got, fault);
        $display("test device_reset done");
        stop_test();
    end
endmodule : test_loop_dac_serial_command_port
